// ===== hw/echo_cfg_regs.sv
// wishbone register bank: echo/no-voice config, coefficient readout, clock and irq status
`timescale 1ns/1ps
`default_nettype none
// Function
// - attenuation select bit chooses 0 dB or 6 dB minimum end echo attenuation.
// - without hysteresis, no-voice holds only while the whole window passes.
// - with hysteresis, no-voice stays asserted for the hang-over delay after detection.
// - ignore-high bit drops samples above log amplitude 126 from detection.
// - floor code 1..15 sets lower limit -42 to 0 dBm0 in 3 dB steps.
// - floor code 0 applies no lower amplitude limit.
// - host writes channel plus monitor bit; coefficients come out in ascending order.
// - coefficient-available request raised for each coefficient placed in data registers.
// - any monitor control write during readout stops that readout at once.
// - clearing the monitor bit stops the readout and resets its index at once; the data registers keep their values.
// - writing 1 over a set monitor bit restarts readout for the new channel.
// - readout ends after the channel's last coefficient and clears the monitor bit.
// - in 128 ms mode, requests for unprocessed channels are ignored.
// - clock status bit reads 1 when its clock input has no valid clock.
// - seven interrupt flags, one per source, in the request register.
// - any set interrupt flag asserts the interrupt output pin.
// - reading the request register clears its flags and drops the pin.
// - masked sources never set their interrupt flag.
// - hang-over delay is evaluated only while hysteresis is enabled.
// - reading the high coefficient register acknowledges coefficient-available; host reads it last.
module echo_cfg_regs #(
    parameter int HANG_STEP_CYCLES = echo_cfg_pkg::HANG_STEP_MS * echo_cfg_pkg::CLK_KHZ
) (
    input wire logic core_clk, // 100 MHz system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write enable
    input wire logic [8:2] adr_i, // wishbone word address
    input wire logic [3:0] sel_i, // wishbone byte selects
    input wire logic [31:0] dat_i, // wishbone write data
    output logic [31:0] dat_o, // wishbone read data
    output logic ack_o, // wishbone acknowledge
    input wire logic mode128, // 128 ms tail mode
    input wire logic masterMode, // device is the master of a pair
    output logic [3:0] minAttenDb, // end echo minimum attenuation in dB
    input wire logic [3:0] hangCode, // hang-over delay code
    input wire logic rxValid, // received sample strobe
    input wire logic [echo_cfg_pkg::AMP_W-1:0] rxAmp, // log amplitude of sample
    input wire logic rxCriterion, // sample meets no-voice criterion
    input wire logic windowEnd, // end of detection window
    output logic noVoice, // no-voice decision
    output logic coeffReq, // fetch request to the filter store
    output logic [4:0] coeffChan, // channel being read out
    output logic [echo_cfg_pkg::CIDX_W-1:0] coeffIndex, // coefficient index
    input wire logic coeffRdValid, // fetched coefficient present
    input wire logic [echo_cfg_pkg::COEFF_W-1:0] coeffRdData, // fetched coefficient
    input wire logic [echo_cfg_pkg::CLK_W-1:0] clkLost, // per clock input, 1 = no clock
    input wire logic watchdogEvt, // watchdog source
    input wire logic syncMissEvt, // missing sync pulse source
    input wire logic testTermEvt, // test termination source
    input wire logic timerEvt, // timer expiry source
    input wire logic sigChangeEvt, // signalling change source
    input wire logic tsMonEvt, // timeslot monitor source
    output logic irqOut // interrupt output, active high
);
    import echo_cfg_pkg::*;

    logic busReq;
    logic wrStb;
    logic rdStb;
    logic wrByte0;
    logic [CONF_W-1:0] echo_voice_detect_config;
    logic [7:0] coeff_monitor_control;
    logic [IRQ_W-1:0] interrupt_mask_reg;
    logic [IRQ_W-1:0] interrupt_request_flags;
    logic [COEFF_W-1:0] coeffData;
    logic coeffIsLast;
    logic [31:0] next_rdData;
    logic monWrite;
    logic chanServed;
    logic startReadout;
    logic coeffLoad;
    logic dataAck;
    logic availEvt;
    logic [IRQ_W-1:0] irqSrc;
    mon_state_t monState;
    mon_state_t next_monState;

    // one access per request; ack drops the cycle after it is given
    always_comb begin
        busReq = cyc_i && stb_i && !ack_o;
        wrStb = busReq && we_i;
        rdStb = busReq && !we_i;
        wrByte0 = wrStb && sel_i[0];
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= busReq;
        end
    end

    // configuration register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            echo_voice_detect_config <= CONF_RST;
        end else if (wrByte0 && adr_i == IDX_CONF) begin
            echo_voice_detect_config <= dat_i[CONF_W-1:0];
        end
    end

    always_comb begin
        if (echo_voice_detect_config[CONF_ATTEN]) begin
            minAttenDb = ATTEN_ON_DB;
        end else begin
            minAttenDb = ATTEN_OFF_DB;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            interrupt_mask_reg <= MASK_RST;
        end else if (wrByte0 && adr_i == IDX_MASK) begin
            interrupt_mask_reg <= dat_i[IRQ_W-1:0];
        end
    end

    // 128 ms mode serves only one half of each group of eight channels
    always_comb begin
        monWrite = wrByte0 && adr_i == IDX_MON;
        chanServed = !mode128 || (dat_i[CHAN_BANK] == !masterMode);
        startReadout = monWrite && dat_i[MON_ON] && chanServed;
    end

    // monitor control: host writes, hardware clears the on bit at the end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            coeff_monitor_control <= MON_RST;
        end else if (monWrite) begin
            coeff_monitor_control <= dat_i[7:0] & MON_WMASK;
            coeff_monitor_control[MON_ON] <= startReadout;
        end else if (coeffLoad && coeffIndex == COEFF_LAST) begin
            coeff_monitor_control[MON_ON] <= 1'b0;
        end
    end

    always_comb begin
        coeffLoad = monState == MON_FETCH && coeffRdValid;
        dataAck = rdStb && adr_i == IDX_CDH;
        availEvt = coeffLoad && !monWrite;
        coeffReq = monState == MON_FETCH;
    end

    // a monitor write always aborts what is running before anything new starts
    always_comb begin
        next_monState = monState;
        unique case (monState)
            MON_IDLE: begin
                next_monState = MON_IDLE;
            end
            MON_FETCH: begin
                if (coeffRdValid && coeffIndex == COEFF_LAST) begin
                    next_monState = MON_IDLE;
                end else if (coeffRdValid) begin
                    next_monState = MON_WAIT;
                end
            end
            MON_WAIT: begin
                if (dataAck) begin
                    next_monState = MON_FETCH;
                end
            end
            default: begin
                next_monState = MON_IDLE;
            end
        endcase
        if (monWrite) begin
            next_monState = startReadout ? MON_FETCH : MON_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            monState <= MON_IDLE;
        end else begin
            monState <= next_monState;
        end
    end

    // ascending walk through coefficients, then aux coefficients
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            coeffIndex <= '0;
            coeffChan <= '0;
        end else if (monWrite) begin
            coeffIndex <= '0;
            coeffChan <= dat_i[CHAN_W-1:0];
        end else if (monState == MON_WAIT && dataAck) begin
            coeffIndex <= coeffIndex + 9'h1;
        end
    end

    // data stays readable after the readout ends
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            coeffData <= '0;
            coeffIsLast <= 1'b0;
        end else if (availEvt) begin
            coeffData <= coeffRdData;
            coeffIsLast <= coeffIndex == COEFF_LAST;
        end
    end

    always_comb begin
        irqSrc = '0;
        irqSrc[IRQ_WATCHDOG] = watchdogEvt;
        irqSrc[IRQ_SYNC] = syncMissEvt;
        irqSrc[IRQ_COEFF] = availEvt;
        irqSrc[IRQ_TEST] = testTermEvt;
        irqSrc[IRQ_TIMER] = timerEvt;
        irqSrc[IRQ_SIG] = sigChangeEvt;
        irqSrc[IRQ_SLOTMON] = tsMonEvt;
    end

    irq_flags u_irq (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .srcEvent(irqSrc),
        .srcMask(interrupt_mask_reg),
        .clearRead(rdStb && adr_i == IDX_IRQ),
        .flags(interrupt_request_flags),
        .irqPin(irqOut)
    );

    novoice_detect #(
        .HANG_STEP_CYCLES(HANG_STEP_CYCLES)
    ) u_novoice (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .hystEn(echo_voice_detect_config[CONF_HYST]),
        .ignoreHigh(echo_voice_detect_config[CONF_IGNHI]),
        .floorCode(echo_voice_detect_config[FLOOR_W-1:0]),
        .hangCode(hangCode),
        .rxValid(rxValid),
        .rxAmp(rxAmp),
        .rxCriterion(rxCriterion),
        .windowEnd(windowEnd),
        .noVoice(noVoice)
    );

    // read mux; unmapped words read zero but are still acknowledged
    always_comb begin
        next_rdData = 32'h0;
        unique case (adr_i)
            IDX_IRQ: begin
                next_rdData[IRQ_W-1:0] = interrupt_request_flags;
            end
            IDX_CLK: begin
                next_rdData[CLK_W-1:0] = clkLost;
            end
            IDX_MASK: begin
                next_rdData[IRQ_W-1:0] = interrupt_mask_reg;
            end
            IDX_CONF: begin
                next_rdData[CONF_W-1:0] = echo_voice_detect_config;
            end
            IDX_MON: begin
                next_rdData[7:0] = coeff_monitor_control;
            end
            IDX_CDH: begin
                next_rdData[7:0] = coeffData[COEFF_W-1:COEFF_HI_LSB];
            end
            IDX_CDL: begin
                next_rdData[CDL_LAST] = coeffIsLast;
                next_rdData[COEFF_HI_LSB-1:0] = coeffData[COEFF_HI_LSB-1:0];
            end
            default: begin
                next_rdData = 32'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dat_o <= 32'h0;
        end else if (rdStb) begin
            dat_o <= next_rdData;
        end
    end
endmodule : echo_cfg_regs
`default_nettype wire

// ===== hw/echo_cfg_pkg.sv
// constants, field layout and types for the echo canceller config/status bank
package echo_cfg_pkg;
    // register indices; byte address is four times the index
    localparam logic [6:0] IDX_IRQ = 7'h08;
    localparam logic [6:0] IDX_CLK = 7'h09;
    localparam logic [6:0] IDX_MASK = 7'h0a;
    localparam logic [6:0] IDX_CONF = 7'h79;
    localparam logic [6:0] IDX_MON = 7'h7a;
    localparam logic [6:0] IDX_CDH = 7'h7b;
    localparam logic [6:0] IDX_CDL = 7'h7c;
    // reset values
    localparam logic [6:0] CONF_RST = 7'h10;
    localparam logic [7:0] MON_RST = 8'h00;
    localparam logic [6:0] MASK_RST = 7'h00;
    // field positions and widths
    localparam int CONF_W = 7;
    localparam int CONF_ATTEN = 6;
    localparam int CONF_HYST = 5;
    localparam int CONF_IGNHI = 4;
    localparam int FLOOR_W = 4;
    localparam int MON_ON = 7;
    localparam int CHAN_W = 5;
    localparam int CHAN_BANK = 2;
    localparam logic [7:0] MON_WMASK = 8'h9f;
    localparam int CDL_LAST = 7;
    localparam int COEFF_W = 14;
    localparam int COEFF_HI_LSB = 6;
    localparam int IRQ_W = 7;
    localparam int IRQ_WATCHDOG = 6;
    localparam int IRQ_SYNC = 5;
    localparam int IRQ_COEFF = 4;
    localparam int IRQ_TEST = 3;
    localparam int IRQ_TIMER = 2;
    localparam int IRQ_SIG = 1;
    localparam int IRQ_SLOTMON = 0;
    localparam int CLK_W = 6;
    // coefficient sequence: filter coefficients followed by aux coefficients
    localparam int CIDX_W = 9;
    localparam logic [CIDX_W-1:0] COEFF_LAST = 9'h17f;
    // amplitude in log units of 0.5 dB, 0 dBm0 at 126
    localparam int AMP_W = 7;
    localparam logic [AMP_W-1:0] AMP_HIGH = 7'h7e;
    localparam logic [AMP_W-1:0] FLOOR_BASE = 7'h2a;
    localparam logic [AMP_W-1:0] FLOOR_STEP = 7'h06;
    localparam logic [3:0] ATTEN_OFF_DB = 4'h0;
    localparam logic [3:0] ATTEN_ON_DB = 4'h6;
    // hang-over timing: 8 ms per code step
    localparam int HANG_STEP_MS = 8;
    localparam int CLK_KHZ = 100000;
    localparam int HANG_CNT_W = 24;

    typedef enum logic [1:0] {
        MON_IDLE = 2'b00,
        MON_FETCH = 2'b01,
        MON_WAIT = 2'b10
    } mon_state_t;

    // lower amplitude limit; code 0 means no limit
    function automatic logic [AMP_W-1:0] floorLimit(input logic [FLOOR_W-1:0] code);
        logic [AMP_W-1:0] steps;
        steps = {3'h0, code} - 7'h01;
        if (code == 4'h0) begin
            floorLimit = 7'h00;
        end else begin
            floorLimit = FLOOR_BASE + 7'(steps * FLOOR_STEP);
        end
    endfunction : floorLimit
endpackage : echo_cfg_pkg

// ===== hw/irq_flags.sv
// sticky interrupt request flags with mask and clear-on-read
`timescale 1ns/1ps
`default_nettype none
module irq_flags (
    input wire logic core_clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic [echo_cfg_pkg::IRQ_W-1:0] srcEvent, // source activity
    input wire logic [echo_cfg_pkg::IRQ_W-1:0] srcMask, // 1 = source masked
    input wire logic clearRead, // host read of the flag register
    output logic [echo_cfg_pkg::IRQ_W-1:0] flags, // flag register
    output logic irqPin // interrupt pin, active high
);
    import echo_cfg_pkg::*;

    logic [IRQ_W-1:0] next_flags;

    // a source firing in the clearing cycle survives the clear
    always_comb begin
        next_flags = (clearRead ? '0 : flags) | (srcEvent & ~srcMask);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // pin follows the flags, so it stays up until the clearing read
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqPin <= 1'b0;
        end else begin
            irqPin <= |next_flags;
        end
    end
endmodule : irq_flags
`default_nettype wire

// ===== hw/novoice_detect.sv
// no-voice decision with amplitude gating and optional hang-over
`timescale 1ns/1ps
`default_nettype none
module novoice_detect #(
    parameter int HANG_STEP_CYCLES = 800000 // cycles per 8 ms hang-over step
) (
    input wire logic core_clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic hystEn, // hysteresis enable
    input wire logic ignoreHigh, // drop loud samples from detection
    input wire logic [echo_cfg_pkg::FLOOR_W-1:0] floorCode, // amplitude floor code
    input wire logic [3:0] hangCode, // hang-over delay code
    input wire logic rxValid, // received sample strobe
    input wire logic [echo_cfg_pkg::AMP_W-1:0] rxAmp, // log amplitude of sample
    input wire logic rxCriterion, // sample meets the no-voice criterion
    input wire logic windowEnd, // last cycle of a detection window
    output logic noVoice // no-voice decision
);
    import echo_cfg_pkg::*;

    logic considered;
    logic windowOk;
    logic windowPass;
    logic [HANG_CNT_W-1:0] hangCnt;
    logic [HANG_CNT_W-1:0] hangLoad;

    always_comb begin
        considered = !(ignoreHigh && rxAmp > AMP_HIGH)
            && rxAmp >= floorLimit(floorCode);
        windowPass = windowOk && !(rxValid && considered && !rxCriterion);
        hangLoad = HANG_CNT_W'(({20'h0, hangCode} + 24'h1) * HANG_CNT_W'(HANG_STEP_CYCLES));
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || windowEnd) begin
            windowOk <= 1'b1;
        end else begin
            windowOk <= windowPass;
        end
    end

    // counter runs only with hysteresis on
    always_ff @(posedge core_clk) begin
        if (sys_rst || !hystEn) begin
            hangCnt <= '0;
        end else if (windowEnd && windowPass) begin
            hangCnt <= hangLoad;
        end else if (hangCnt != '0) begin
            hangCnt <= hangCnt - 24'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            noVoice <= 1'b0;
        end else if (windowEnd && windowPass) begin
            noVoice <= 1'b1;
        end else if (!hystEn && windowEnd) begin
            noVoice <= 1'b0;
        end else if (hystEn && hangCnt == '0) begin
            noVoice <= 1'b0;
        end
    end
endmodule : novoice_detect
`default_nettype wire

// ===== testbench/echo_cfg_props.sv
// assertion checker for the echo config register bank
`timescale 1ns/1ps
`default_nettype none
module echo_cfg_props (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic cyc_i, // cycle
    input wire logic stb_i, // strobe
    input wire logic we_i, // write
    input wire logic [8:2] adr_i, // index
    input wire logic [3:0] sel_i, // selects
    input wire logic [31:0] dat_i, // write data
    input wire logic [31:0] dat_o, // read data
    input wire logic ack_o, // acknowledge
    input wire logic mode128, // tail mode
    input wire logic [3:0] minAttenDb, // attenuation
    input wire logic coeffReq, // fetch
    input wire logic [4:0] coeffChan, // channel
    input wire logic [echo_cfg_pkg::CIDX_W-1:0] coeffIndex, // index
    input wire logic coeffRdValid, // fetched
    input wire logic [echo_cfg_pkg::CLK_W-1:0] clkLost, // clock loss
    input wire logic irqOut // interrupt
);
    import echo_cfg_pkg::*;
    // request fields are still held in the ack cycle, so no $past on them
    wire take = cyc_i && stb_i && !ack_o;
    wire wr = take && we_i && sel_i[0];
    wire monWr = wr && adr_i == IDX_MON;
    wire rdIrq = take && !we_i && adr_i == IDX_IRQ;
    logic coeffMasked;
    // a masked coefficient source legally leaves the pin low
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            coeffMasked <= 1'b0;
        end else if (wr && adr_i == IDX_MASK) begin
            coeffMasked <= dat_i[IRQ_COEFF];
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    atten_follow_a: assert property (wr && adr_i == IDX_CONF |=>
        minAttenDb == (dat_i[CONF_ATTEN] ? ATTEN_ON_DB : ATTEN_OFF_DB))
        else $error("attenuation does not follow config");
    clk_status_a: assert property (take && !we_i && adr_i == IDX_CLK |=>
        dat_o == {26'h0, $past(clkLost)}) else $error("clock status read wrong");
    irq_fall_a: assert property ($fell(irqOut) |-> $past(rdIrq))
        else $error("interrupt dropped without flag read");
    ca_raise_a: assert property (coeffReq && coeffRdValid && !monWr && !coeffMasked |=> irqOut)
        else $error("no interrupt for loaded coefficient");
    fetch_start_a: assert property (monWr && dat_i[MON_ON] && !mode128 |=>
        coeffReq && coeffIndex == 9'h000 && coeffChan == dat_i[4:0])
        else $error("readout did not start");
    fetch_hold_a: assert property (coeffReq && !coeffRdValid && !monWr |=> coeffReq)
        else $error("fetch request dropped early");
    abort_stop_a: assert property (monWr && !dat_i[MON_ON] |=> !coeffReq [*2])
        else $error("readout not stopped");
    mon_bit_a: assert property (take && !we_i && adr_i == IDX_MON && coeffReq |=>
        dat_o[MON_ON]) else $error("monitor bit clear during fetch");
endmodule : echo_cfg_props

bind echo_cfg_regs echo_cfg_props u_props (.core_clk, .sys_rst, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .mode128, .minAttenDb, .coeffReq, .coeffChan,
    .coeffIndex, .coeffRdValid, .clkLost, .irqOut);
`default_nettype wire

// ===== testbench/coeff_store.sv
// behavioural filter store answering coefficient fetches
`timescale 1ns/1ps
`default_nettype none
module coeff_store (
    input wire logic core_clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic coeffReq, // fetch request
    input wire logic [4:0] coeffChan, // channel
    input wire logic [echo_cfg_pkg::CIDX_W-1:0] coeffIndex, // index
    input wire logic slow, // long fetch latency
    output logic coeffRdValid, // data strobe
    output logic [echo_cfg_pkg::COEFF_W-1:0] coeffRdData // fetched word
);
    import echo_cfg_pkg::*;
    logic [3:0] waitCnt;
    // data flips outside the strobe so a stale sample never matches
    always_ff @(posedge core_clk) begin
        coeffRdValid <= 1'b0;
        coeffRdData <= ~coeffRdData;
        if (sys_rst) begin
            waitCnt <= 4'h0;
            coeffRdData <= '0;
        end else if (!coeffReq || coeffRdValid) begin
            waitCnt <= 4'h0;
        end else if (waitCnt >= (slow ? 4'hc : 4'h1)) begin
            coeffRdValid <= 1'b1;
            coeffRdData <= {coeffChan, coeffIndex};
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule : coeff_store
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the echo config register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import echo_cfg_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [8:2] adr_i = '0;
    logic [3:0] sel_i = '0, minAttenDb, hangCode = 4'hf;
    logic [31:0] dat_i = '0, dat_o, q;
    logic ack_o, noVoice, coeffReq, coeffRdValid, irqOut;
    logic mode128 = 1'b0, masterMode = 1'b0, slow = 1'b0;
    logic rxValid = 1'b0, rxCriterion = 1'b0, windowEnd = 1'b0;
    logic [6:0] rxAmp = '0;
    logic [4:0] coeffChan;
    logic [8:0] coeffIndex;
    logic [13:0] coeffRdData;
    logic [5:0] clkLost = '0, evt = '0;
    logic [23:0] rows [0:12] = '{24'h003211, 24'h000000, 24'h003211, 24'h007f00,
        24'h107f01, 24'h012901, 24'h012a00, 24'h0f7d01, 24'h0f7e00, 24'h203211,
        24'h203201, 24'h003211, 24'h003200};
    int err_count = 0, samples_checked = 0, k;

    echo_cfg_regs #(.HANG_STEP_CYCLES(4)) u_dut (.core_clk, .sys_rst, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .mode128, .masterMode, .minAttenDb,
        .hangCode, .rxValid, .rxAmp, .rxCriterion, .windowEnd, .noVoice, .coeffReq,
        .coeffChan, .coeffIndex, .coeffRdValid, .coeffRdData, .clkLost,
        .watchdogEvt(evt[5]), .syncMissEvt(evt[4]), .testTermEvt(evt[3]),
        .timerEvt(evt[2]), .sigChangeEvt(evt[1]), .tsMonEvt(evt[0]), .irqOut);
    coeff_store u_store (.core_clk, .sys_rst, .coeffReq, .coeffChan, .coeffIndex, .slow,
        .coeffRdValid, .coeffRdData);

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task summarize;
        $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task wb(input logic w, input logic [6:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge core_clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do begin
            @(posedge core_clk);
            t++;
        end while (ack_o !== 1'b1 && t < 40);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (t >= 40) begin
            err_count++;
            summarize();
        end
    endtask : wb

    task rdc(input string what, input logic [6:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask : rdc

    task waitirq;
        int t;
        t = 0;
        while (irqOut !== 1'b1 && t < 200) begin
            @(posedge core_clk);
            t++;
        end
        if (t >= 200) begin
            err_count++;
            summarize();
        end
    endtask : waitirq

    task win(input logic [6:0] a, input logic c);
        @(posedge core_clk);
        rxValid <= 1'b1;
        rxAmp <= a;
        rxCriterion <= c;
        windowEnd <= 1'b1;
        @(posedge core_clk);
        rxValid <= 1'b0;
        windowEnd <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : win

    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdc("config reset", IDX_CONF, CONF_RST);
        rdc("monitor reset", IDX_MON, MON_RST);
        rdc("mask reset", IDX_MASK, MASK_RST);
        wb(1'b1, 7'h01, 32'hff);
        rdc("unmapped", 7'h01, 32'h0);
        wb(1'b1, IDX_CONF, 32'h40);
        chk("attenuation", ATTEN_ON_DB, minAttenDb);
        wb(1'b1, IDX_CONF, 32'h00);
        chk("attenuation", ATTEN_OFF_DB, minAttenDb);
        for (k = 0; k < CLK_W; k++) begin
            clkLost <= 6'(1 << k);
            rdc("clock status", IDX_CLK, 32'(1 << k));
        end
        for (k = 0; k < 6; k++) begin
            evt <= 6'(1 << k);
            @(posedge core_clk);
            evt <= '0;
            @(posedge core_clk);
            chk("irq pin set", 1, irqOut);
            rdc("irq flags", IDX_IRQ, 32'(1 << (k > 3 ? k + 1 : k)));
            chk("irq pin cleared", 0, irqOut);
        end
        wb(1'b1, IDX_MASK, 32'h40);
        evt <= 6'h20;
        @(posedge core_clk);
        evt <= '0;
        repeat (2) @(posedge core_clk);
        chk("masked pin", 0, irqOut);
        rdc("masked flags", IDX_IRQ, 32'h0);
        wb(1'b1, IDX_MASK, 32'h0);
        // full readout, latency alternating between fast and slow fetches
        wb(1'b1, IDX_MON, 32'h83);
        for (k = 0; k <= int'(COEFF_LAST); k++) begin
            slow <= k[0];
            waitirq();
            rdc("ca flag", IDX_IRQ, 32'h10);
            rdc("coeff low", IDX_CDL, {24'h0, k == int'(COEFF_LAST), 1'b0, k[5:0]});
            rdc("coeff high", IDX_CDH, {24'h0, 5'h03, k[8:6]});
        end
        rdc("monitor done", IDX_MON, 32'h03);
        slow <= 1'b1;
        wb(1'b1, IDX_MON, 32'h85);
        waitirq();
        rdc("ca flag", IDX_IRQ, 32'h10);
        wb(1'b1, IDX_MON, 32'h86);
        waitirq();
        rdc("ca flag", IDX_IRQ, 32'h10);
        rdc("restart low", IDX_CDL, 32'h00);
        rdc("restart high", IDX_CDH, 32'h30);
        wb(1'b1, IDX_MON, 32'h06);
        repeat (30) @(posedge core_clk);
        chk("aborted irq", 0, irqOut);
        chk("aborted fetch", 0, coeffReq);
        rdc("monitor off", IDX_MON, 32'h06);
        mode128 <= 1'b1;
        for (k = 0; k < 4; k++) begin
            masterMode <= k[1];
            wb(1'b1, IDX_MON, {24'h0, 8'h83 | {5'h0, k[0], 2'h0}});
            rdc("channel filter", IDX_MON, {24'h0, k[1] ^ k[0], 4'h0, k[0], 2'h3});
            chk("channel fetch", k[1] ^ k[0], coeffReq);
            wb(1'b1, IDX_MON, 32'h0);
        end
        for (k = 0; k < 13; k++) begin
            if (k == 11) begin
                repeat (100) @(posedge core_clk);
                chk("hang-over end", 0, noVoice);
            end
            wb(1'b1, IDX_CONF, {24'h0, rows[k][23:16]});
            win(rows[k][14:8], rows[k][4]);
            chk("no-voice", rows[k][0], noVoice);
        end
        summarize();
    end
endmodule : tb
`default_nettype wire
